// >>> reset_ctrl_pkg.sv
// Shared constants for the start-up and reset controller
package reset_ctrl_pkg;
   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_RESET_CONTROL = 8'h00;
   localparam logic [7:0] OFF_RESET_STATUS = 8'h04;
   localparam logic [7:0] OFF_KEY_CONTROL = 8'h08;
   localparam logic [7:0] OFF_SUPPLY_CONTROL = 8'h0c;
   localparam logic [7:0] OFF_PIN0_CONTROL = 8'h10;
   localparam logic [7:0] OFF_PIN1_CONTROL = 8'h14;
   localparam logic [7:0] OFF_SINK0_CODE = 8'h18;
   localparam logic [7:0] OFF_SINK1_CODE = 8'h1c;
   localparam logic [7:0] OFF_RESET_TIMER = 8'h20;
   localparam logic [7:0] OFF_STATE = 8'h24;

   // Reset control fields
   localparam int BIT_FORCE_RESET = 0;
   localparam int BIT_LPRESS_EN = 1;

   // Reset status fields (cause of last reset cycle)
   localparam int ST_W = 6;
   localparam int BIT_CAUSE_POR = 0;
   localparam int BIT_CAUSE_FALL = 1;
   localparam int BIT_CAUSE_SW = 2;
   localparam int BIT_CAUSE_EXT = 3;
   localparam int BIT_CAUSE_KEY = 4;
   localparam int BIT_CAUSE_HOT = 5;

   // Key control fields
   localparam int KEY_W = 4;
   localparam int BIT_KEY_INVERT = 0;
   localparam int BIT_KEY_SWITCH = 1;
   localparam int BIT_LPRESS_SHORT = 2;
   localparam int BIT_LPRESS_RESET = 3;
   localparam logic [3:0] KEY_CONTROL_RST = 4'h0;

   // Supply control fields
   localparam int SUP_W = 4;
   localparam int BIT_SUPPLY_RESET_ENABLE = 0;
   localparam int BIT_FAST_MASK_ENABLE = 1;
   localparam int BIT_LOWSUPPLY_SHUTDOWN = 2;
   localparam int BIT_OVERHEAT_RESET_ENABLE = 3;
   localparam logic [3:0] SUPPLY_CONTROL_RST = 4'h0;

   // Pin control: direction select [1:0], function select [4:2]
   localparam int PIN_W = 5;
   localparam int DIR_LSB = 0;
   localparam int DIR_W = 2;
   localparam int FUNC_LSB = 2;
   localparam int FUNC_W = 3;
   localparam logic [1:0] DIR_SINK = 2'h2;
   localparam int FUNC_OUT_BIT = 2;
   localparam logic [4:0] PIN_CONTROL_RST = 5'h00;

   // Sink code and reset timer
   localparam int CODE_W = 8;
   localparam logic [7:0] SINK_CODE_RST = 8'h00;
   localparam logic [7:0] RESET_TIMER_RST = 8'h00;

   // Timing
   localparam int CLK_MHZ = 100;
   localparam int MS_US = 1000;
   localparam int MS_CYCLES = MS_US * CLK_MHZ;
   localparam int MASK_SLOW_MS = 3;
   localparam int MASK_FAST_US = 64;
   localparam int MASK_SLOW_CYCLES = MASK_SLOW_MS * MS_CYCLES;
   localparam int MASK_FAST_CYCLES = MASK_FAST_US * CLK_MHZ;
   localparam int LPRESS_LONG_S = 8;
   localparam int LPRESS_SHORT_S = 4;
   localparam int LPRESS_LONG_MS = LPRESS_LONG_S * MS_US;
   localparam int LPRESS_SHORT_MS = LPRESS_SHORT_S * MS_US;
   localparam int CNT_W = 32;
endpackage

// >>> hold_timer_if.sv
// Condition, tick and limit into a hold timer, fire flag back
`timescale 1ns/1ps
`default_nettype none
interface hold_timer_if;
   logic cond;
   logic tick;
   logic [31:0] limit;
   logic fire;
   modport user (output cond, output tick, output limit, input fire);
   modport timer (input cond, input tick, input limit, output fire);
endinterface
`default_nettype wire

// >>> hold_timer.sv
// Counts ticks while a condition holds and flags when it held long enough
`timescale 1ns/1ps
`default_nettype none
module hold_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Condition and result
   hold_timer_if.timer hold
);
   import reset_ctrl_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic fire_q;

   // Any gap in the condition restarts the count from zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
      end else if (!hold.cond) begin
         cnt_q <= '0;
      end else if (hold.tick && cnt_q < hold.limit) begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   // Fire only while the condition still holds
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fire_q <= 1'b0;
      end else begin
         fire_q <= hold.cond && (cnt_q >= hold.limit);
      end
   end

   assign hold.fire = fire_q;
endmodule
`default_nettype wire

// >>> pmic_startup_reset_control.sv
// Start-up sequencer and reset controller with register port
//
// Functional notes
// - Sink mode needs sink direction plus output function
// - Eight-bit code sets each sink current
// - Four wake sources begin a start-up
// - Apply limits and rise threshold, then read boot
// - Hold reset until reset timer expires
// - Key polarity bit sets level and pull-down
// - Reset pin driven low through every cycle
// - Reset cycle defaults all but control, status
// - Six causes start a reset cycle
// - Power-on reset held until rise threshold
// - Falling supply acted on only after mask
// - Enable bit picks 2.7V or fall threshold
// - Forced-reset bit resets and clears itself
// - External low edge on reset pin resets
// - Long-press reset needs enable and reset action
// - Long press lasts 8s or 4s by bit
// - No long-press reset in switch configuration
// - Mask time 3 ms or 64 us
// - Overheat with enable starts reset cycle
`timescale 1ns/1ps
`default_nettype none
module pmic_startup_reset_control #(
   parameter int MS_CYC = reset_ctrl_pkg::MS_CYCLES,
   parameter int MASK_SLOW_CYC = reset_ctrl_pkg::MASK_SLOW_CYCLES,
   parameter int MASK_FAST_CYC = reset_ctrl_pkg::MASK_FAST_CYCLES,
   parameter int LPRESS_LONG_TICKS = reset_ctrl_pkg::LPRESS_LONG_MS,
   parameter int LPRESS_SHORT_TICKS = reset_ctrl_pkg::LPRESS_SHORT_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register port
   input wire logic [reset_ctrl_pkg::ADDR_W-1:0] addr,
   input wire logic [reset_ctrl_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [reset_ctrl_pkg::DATA_W-1:0] rdata,
   // Supply monitors and wake sources
   input wire logic supply_above_por,
   input wire logic supply_above_rise,
   input wire logic supply_below_fall,
   input wire logic supply_below_min,
   input wire logic battery_inserted,
   input wire logic charger_inserted,
   input wire logic overheat,
   // On key
   input wire logic on_key,
   output logic key_pulldown_en,
   // System reset pin
   input wire logic system_reset_n_in,
   output logic system_reset_n_out,
   output logic system_reset_n_oe,
   // Start-up controls
   output logic usb_limit_apply,
   output logic rise_threshold_apply,
   output logic boot_rd_req,
   input wire logic boot_rd_ack,
   input wire logic [reset_ctrl_pkg::CODE_W-1:0] boot_timer_code,
   output logic supply_fall_warn,
   // Current sinks
   output logic [1:0] sink_en,
   output logic [reset_ctrl_pkg::CODE_W-1:0] sink_current_code0,
   output logic [reset_ctrl_pkg::CODE_W-1:0] sink_current_code1
);
   import reset_ctrl_pkg::*;

   typedef enum logic [2:0] {
      ST_OFF, ST_CLEAR, ST_LIMITS, ST_BOOT, ST_TIMER, ST_RISE, ST_RUN
   } seq_state_t;

   seq_state_t state_q, state_d;
   logic force_reset_q, lpress_en_q;
   logic [ST_W-1:0] status_q, cause;
   logic [KEY_W-1:0] key_ctrl_q;
   logic [SUP_W-1:0] sup_ctrl_q;
   logic [PIN_W-1:0] pin_ctrl_q [2];
   logic [CODE_W-1:0] sink_code_q [2];
   logic [CODE_W-1:0] res_timer_q;
   logic [CNT_W-1:0] ms_cnt_q;
   logic ms_tick_q;
   logic [CODE_W-1:0] tmr_cnt_q;
   logic pin_prev_q, por_prev_q, rise_prev_q;
   logic rdata_valid;
   logic [DATA_W-1:0] rdata_q;
   logic rst_oe_q, pd_q, usb_q, rise_q, boot_q, warn_q;
   logic [1:0] sink_en_q;
   logic wake, any_cause, key_active, fall_cond, do_clear, wr_ok;

   hold_timer_if mask_if ();
   hold_timer_if press_if ();

   // Millisecond enable from the system clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ms_cnt_q <= '0;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q == CNT_W'(MS_CYC - 1)) begin
         ms_cnt_q <= '0;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q <= ms_cnt_q + 32'h1;
         ms_tick_q <= 1'b0;
      end
   end

   // Falling-supply mask timer
   assign fall_cond = sup_ctrl_q[BIT_SUPPLY_RESET_ENABLE] ? supply_below_fall
                                                         : supply_below_min;
   assign mask_if.cond = fall_cond;
   assign mask_if.tick = 1'b1;
   assign mask_if.limit = sup_ctrl_q[BIT_FAST_MASK_ENABLE] ? CNT_W'(MASK_FAST_CYC)
                                                          : CNT_W'(MASK_SLOW_CYC);
   hold_timer u_mask (
      .clk(clk),
      .arst_n(arst_n),
      .hold(mask_if.timer)
   );

   // Long-press timer; key release restarts it
   assign key_active = on_key ^ key_ctrl_q[BIT_KEY_INVERT];
   assign press_if.cond = key_active;
   assign press_if.tick = ms_tick_q;
   assign press_if.limit = key_ctrl_q[BIT_LPRESS_SHORT] ? CNT_W'(LPRESS_SHORT_TICKS)
                                                       : CNT_W'(LPRESS_LONG_TICKS);
   hold_timer u_press (
      .clk(clk),
      .arst_n(arst_n),
      .hold(press_if.timer)
   );

   // Reset causes, sampled while the system runs; power-on edge only while off
   always_comb begin
      cause = '0;
      if (state_q == ST_RUN) begin
         cause[BIT_CAUSE_FALL] = mask_if.fire;
         cause[BIT_CAUSE_SW] = force_reset_q;
         cause[BIT_CAUSE_EXT] = pin_prev_q && !system_reset_n_in;
         cause[BIT_CAUSE_KEY] = press_if.fire && lpress_en_q
            && key_ctrl_q[BIT_LPRESS_RESET]
            && !key_ctrl_q[BIT_KEY_SWITCH];
         cause[BIT_CAUSE_HOT] = overheat
            && sup_ctrl_q[BIT_OVERHEAT_RESET_ENABLE];
      end else if (state_q == ST_OFF) begin
         cause[BIT_CAUSE_POR] = supply_above_por && !por_prev_q;
      end
   end
   assign any_cause = |cause;

   // Wake sources while powered off
   assign wake = battery_inserted
      || (charger_inserted && supply_below_fall)
      || key_active
      || (supply_above_rise && !rise_prev_q);

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (any_cause || wake) begin
               state_d = ST_CLEAR;
            end
         end
         ST_CLEAR: state_d = ST_LIMITS;
         ST_LIMITS: state_d = ST_BOOT;
         ST_BOOT: begin
            if (boot_rd_ack) begin
               state_d = ST_TIMER;
            end
         end
         ST_TIMER: begin
            if (ms_tick_q && tmr_cnt_q >= res_timer_q) begin
               state_d = ST_RISE;
            end
         end
         ST_RISE: begin
            if (supply_above_rise) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (any_cause) begin
               state_d = ST_CLEAR;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   // Sequencer state and edge history
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_OFF;
         pin_prev_q <= 1'b0;
         por_prev_q <= 1'b0;
         rise_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pin_prev_q <= system_reset_n_in;
         por_prev_q <= supply_above_por;
         rise_prev_q <= supply_above_rise;
      end
   end

   // Reset timer counts milliseconds from zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tmr_cnt_q <= '0;
      end else if (state_q != ST_TIMER) begin
         tmr_cnt_q <= '0;
      end else if (ms_tick_q && tmr_cnt_q != '1) begin
         tmr_cnt_q <= tmr_cnt_q + 8'h1;
      end
   end

   assign do_clear = (state_q == ST_CLEAR);
   assign wr_ok = wr && !do_clear;

   // Long-press enable and status keep their contents over a reset cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         force_reset_q <= 1'b0;
         lpress_en_q <= 1'b0;
      end else if (do_clear) begin
         force_reset_q <= 1'b0;
      end else if (wr && addr == OFF_RESET_CONTROL) begin
         force_reset_q <= wdata[BIT_FORCE_RESET];
         lpress_en_q <= wdata[BIT_LPRESS_EN];
      end
   end

   // Cause flags: set wins over a write-one clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= '0;
      end else if (wr && addr == OFF_RESET_STATUS) begin
         status_q <= (status_q & ~wdata[ST_W-1:0]) | cause;
      end else begin
         status_q <= status_q | cause;
      end
   end

   // Ordinary registers return to defaults on each reset cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         key_ctrl_q <= KEY_CONTROL_RST;
         sup_ctrl_q <= SUPPLY_CONTROL_RST;
         pin_ctrl_q[0] <= PIN_CONTROL_RST;
         pin_ctrl_q[1] <= PIN_CONTROL_RST;
         sink_code_q[0] <= SINK_CODE_RST;
         sink_code_q[1] <= SINK_CODE_RST;
      end else if (do_clear) begin
         key_ctrl_q <= KEY_CONTROL_RST;
         sup_ctrl_q <= SUPPLY_CONTROL_RST;
         pin_ctrl_q[0] <= PIN_CONTROL_RST;
         pin_ctrl_q[1] <= PIN_CONTROL_RST;
         sink_code_q[0] <= SINK_CODE_RST;
         sink_code_q[1] <= SINK_CODE_RST;
      end else if (wr_ok) begin
         case (addr)
            OFF_KEY_CONTROL: key_ctrl_q <= wdata[KEY_W-1:0];
            OFF_SUPPLY_CONTROL: sup_ctrl_q <= wdata[SUP_W-1:0];
            OFF_PIN0_CONTROL: pin_ctrl_q[0] <= wdata[PIN_W-1:0];
            OFF_PIN1_CONTROL: pin_ctrl_q[1] <= wdata[PIN_W-1:0];
            OFF_SINK0_CODE: sink_code_q[0] <= wdata[CODE_W-1:0];
            OFF_SINK1_CODE: sink_code_q[1] <= wdata[CODE_W-1:0];
            default: ;
         endcase
      end
   end

   // Reset timer comes from boot memory, software may change it later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         res_timer_q <= RESET_TIMER_RST;
      end else if (do_clear) begin
         res_timer_q <= RESET_TIMER_RST;
      end else if (state_q == ST_BOOT && boot_rd_ack) begin
         res_timer_q <= boot_timer_code;
      end else if (wr && addr == OFF_RESET_TIMER) begin
         res_timer_q <= wdata[CODE_W-1:0];
      end
   end

   // Read data stands for the one cycle after the strobe
   always_comb begin
      rdata_valid = 1'b1;
      case (addr)
         OFF_RESET_CONTROL: rdata_q = DATA_W'({lpress_en_q, force_reset_q});
         OFF_RESET_STATUS: rdata_q = DATA_W'(status_q);
         OFF_KEY_CONTROL: rdata_q = DATA_W'(key_ctrl_q);
         OFF_SUPPLY_CONTROL: rdata_q = DATA_W'(sup_ctrl_q);
         OFF_PIN0_CONTROL: rdata_q = DATA_W'(pin_ctrl_q[0]);
         OFF_PIN1_CONTROL: rdata_q = DATA_W'(pin_ctrl_q[1]);
         OFF_SINK0_CODE: rdata_q = DATA_W'(sink_code_q[0]);
         OFF_SINK1_CODE: rdata_q = DATA_W'(sink_code_q[1]);
         OFF_RESET_TIMER: rdata_q = DATA_W'(res_timer_q);
         OFF_STATE: rdata_q = DATA_W'(state_q);
         default: begin
            rdata_q = '0;
            rdata_valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else if (rd && rdata_valid) begin
         rdata <= rdata_q;
      end else begin
         rdata <= '0;
      end
   end

   // Reset pin: driven low in every state but run
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_oe_q <= 1'b1;
      end else begin
         rst_oe_q <= (state_d != ST_RUN);
      end
   end

   // Start-up steps; limits stay applied once set
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         usb_q <= 1'b0;
         rise_q <= 1'b0;
         boot_q <= 1'b0;
      end else begin
         if (state_q == ST_LIMITS) begin
            usb_q <= 1'b1;
            rise_q <= 1'b1;
         end
         boot_q <= (state_d == ST_BOOT) && !(state_q == ST_BOOT && boot_rd_ack);
      end
   end

   // Pull-down, fall warning and sink enables
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pd_q <= 1'b1;
         warn_q <= 1'b0;
         sink_en_q <= '0;
      end else begin
         pd_q <= !key_ctrl_q[BIT_KEY_INVERT];
         warn_q <= supply_below_fall && !sup_ctrl_q[BIT_SUPPLY_RESET_ENABLE];
         for (int i = 0; i < 2; i++) begin
            sink_en_q[i] <= (pin_ctrl_q[i][DIR_LSB +: DIR_W] == DIR_SINK)
               && pin_ctrl_q[i][FUNC_LSB + FUNC_OUT_BIT]
               && (sink_code_q[i] != SINK_CODE_RST);
         end
      end
   end

   assign system_reset_n_out = 1'b0;
   assign system_reset_n_oe = rst_oe_q;
   assign key_pulldown_en = pd_q;
   assign usb_limit_apply = usb_q;
   assign rise_threshold_apply = rise_q;
   assign boot_rd_req = boot_q;
   assign supply_fall_warn = warn_q;
   assign sink_en = sink_en_q;
   assign sink_current_code0 = sink_code_q[0];
   assign sink_current_code1 = sink_code_q[1];
endmodule
`default_nettype wire

// >>> rst_ctrl_monitor.sv
// Checker of reset pin, start-up order and sink enables
`timescale 1ns/1ps
`default_nettype none
module rst_ctrl_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Reset pin
   input wire logic system_reset_n_in,
   input wire logic system_reset_n_out,
   input wire logic system_reset_n_oe,
   // Start-up
   input wire logic supply_above_rise,
   input wire logic usb_limit_apply,
   input wire logic rise_threshold_apply,
   input wire logic boot_rd_req,
   input wire logic boot_rd_ack,
   // Sinks
   input wire logic [1:0] sink_en,
   input wire logic [reset_ctrl_pkg::CODE_W-1:0] sink_current_code0,
   input wire logic [reset_ctrl_pkg::CODE_W-1:0] sink_current_code1
);
   import reset_ctrl_pkg::*;
   // One domain, so clock and disable are shared
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property p_pin_low;
      $rose(system_reset_n_oe) |-> !system_reset_n_out ##1 system_reset_n_oe [*3];
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin not driven low");
   property p_limits_first;
      boot_rd_req |-> usb_limit_apply && rise_threshold_apply;
   endproperty
   a_limits_first: assert property (p_limits_first) else $error("boot read before limits");
   property p_boot_wait;
      boot_rd_req && !boot_rd_ack |=> boot_rd_req;
   endproperty
   a_boot_wait: assert property (p_boot_wait) else $error("boot request dropped");
   property p_boot_in_reset;
      boot_rd_req |-> system_reset_n_oe;
   endproperty
   a_boot_in_reset: assert property (p_boot_in_reset) else $error("pin free while booting");
   // Release only after rise threshold and finished boot read
   property p_release_rise;
      $fell(system_reset_n_oe) |-> $past(supply_above_rise) && !boot_rd_req;
   endproperty
   a_release_rise: assert property (p_release_rise) else $error("early release");
   property p_ext_edge;
      !system_reset_n_oe && $past(system_reset_n_in) && !system_reset_n_in
         |-> ##[0:2] system_reset_n_oe;
   endproperty
   a_ext_edge: assert property (p_ext_edge) else $error("pin pull ignored");
   // Code may change beside the enable, so either side counts
   property p_sink0;
      sink_en[0] |-> sink_current_code0 != 8'h00 || $past(sink_current_code0) != 8'h00;
   endproperty
   a_sink0: assert property (p_sink0) else $error("sink 0 on with zero code");
   property p_sink1;
      sink_en[1] |-> sink_current_code1 != 8'h00 || $past(sink_current_code1) != 8'h00;
   endproperty
   a_sink1: assert property (p_sink1) else $error("sink 1 on with zero code");
endmodule
bind pmic_startup_reset_control rst_ctrl_monitor u_rst_ctrl_monitor (
   .clk(clk), .arst_n(arst_n), .system_reset_n_in(system_reset_n_in),
   .system_reset_n_out(system_reset_n_out), .system_reset_n_oe(system_reset_n_oe),
   .supply_above_rise(supply_above_rise), .usb_limit_apply(usb_limit_apply),
   .rise_threshold_apply(rise_threshold_apply), .boot_rd_req(boot_rd_req),
   .boot_rd_ack(boot_rd_ack), .sink_en(sink_en),
   .sink_current_code0(sink_current_code0), .sink_current_code1(sink_current_code1));
`default_nettype wire

// >>> rst_pin_partner.sv
// Host side of the reset pin: pull-up plus an open-drain puller
`timescale 1ns/1ps
`default_nettype none
module rst_pin_partner (
   // Device side
   input wire logic dev_oe,
   input wire logic dev_out,
   // Host pull request
   input wire logic pull_req,
   // Resolved wire
   output logic pin
);
   // Pull-up wins only when nobody sinks the wire
   assign pin = !((dev_oe && !dev_out) || pull_req);
endmodule
`default_nettype wire

// >>> tb_pmic_startup_reset_control.sv
// Self-checking bench of the start-up and reset controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_pmic_startup_reset_control;
   import reset_ctrl_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic [DATA_W-1:0] rdata;
   logic wr = 1'b0, rd = 1'b0, rise = 1'b0, below_fall = 1'b0, below_min = 1'b0;
   logic overheat = 1'b0, on_key = 1'b0, pull_req = 1'b0, back = 1'b0;
   logic por = 1'b1, batt = 1'b0, chg = 1'b0;
   logic [7:0] boot_code = 8'h04;
   logic pin, oe, out, pd, usb, risea, breq, warn;
   logic [1:0] sink_en;
   logic [7:0] code0, code1;
   int mismatches = 0;
   int checks_done = 0;
   int n;
   pmic_startup_reset_control #(.MS_CYC(10), .MASK_SLOW_CYC(30), .MASK_FAST_CYC(6),
      .LPRESS_LONG_TICKS(8), .LPRESS_SHORT_TICKS(4)) u_pmic_startup_reset_control (
      .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .supply_above_por(por), .supply_above_rise(rise),
      .supply_below_fall(below_fall), .supply_below_min(below_min),
      .battery_inserted(batt), .charger_inserted(chg), .overheat(overheat),
      .on_key(on_key), .key_pulldown_en(pd), .system_reset_n_in(pin),
      .system_reset_n_out(out), .system_reset_n_oe(oe), .usb_limit_apply(usb),
      .rise_threshold_apply(risea), .boot_rd_req(breq), .boot_rd_ack(back),
      .boot_timer_code(boot_code), .supply_fall_warn(warn), .sink_en(sink_en),
      .sink_current_code0(code0), .sink_current_code1(code1));
   rst_pin_partner u_rst_pin_partner (.dev_oe(oe), .dev_out(out), .pull_req(pull_req),
      .pin(pin));
   initial begin
      forever #5 clk = !clk;
   end
   // Boot memory answers one cycle after each request
   always @(posedge clk) begin
      back <= breq && !back;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(nm, e, rdata)
   endtask
   // Lets a started cycle show, then waits for the pin release
   task automatic wait_run(output int c);
      c = 0;
      repeat (3) @(posedge clk);
      #1;
      while (oe !== 1'b0 && c < 500) begin
         @(posedge clk);
         #1;
         c++;
      end
      `CHK("run reached", 1'b1, c < 500)
   endtask
   task automatic drive(input int sel, input logic v);
      case (sel)
         0: on_key <= v;
         1: below_fall <= v;
         2: below_min <= v;
         3: overheat <= v;
         default: pull_req <= v;
      endcase
   endtask
   // Two holds with a short gap, then the recorded cause is compared
   task automatic run_case(input logic [3:0] c00, c08, c0c, input int sel, len,
      input logic [31:0] exp);
      int c;
      wr_reg(OFF_RESET_STATUS, 32'h3f);
      wr_reg(OFF_RESET_CONTROL, {28'h0, c00});
      wr_reg(OFF_KEY_CONTROL, {28'h0, c08});
      wr_reg(OFF_SUPPLY_CONTROL, {28'h0, c0c});
      repeat (2) begin
         @(posedge clk);
         drive(sel, 1'b1);
         repeat (len) @(posedge clk);
         #1;
         if (sel == 1 && exp == 0) `CHK("fall warn", !c0c[0], warn)
         @(posedge clk);
         drive(sel, 1'b0);
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      rd_chk(OFF_RESET_STATUS, exp, "reset cause");
      wait_run(c);
   endtask
   // Roughly twenty times the expected length of all tests
   initial begin
      #500000;
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      repeat (100) @(posedge clk);
      #1;
      `CHK("pin held before rise", 1'b1, oe)
      @(posedge clk);
      rise <= 1'b1;
      wait_run(n);
      rd_chk(OFF_RESET_STATUS, 32'h1, "por cause");
      rd_chk(OFF_STATE, 32'h6, "state");
      rd_chk(OFF_KEY_CONTROL, 32'h0, "key control");
      rd_chk(8'h40, 32'h0, "unmapped");
      `CHK("pull-down", 1'b1, pd)
      wr_reg(OFF_KEY_CONTROL, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      `CHK("pull-down off", 1'b0, pd)
      wr_reg(OFF_PIN0_CONTROL, 32'h12);
      wr_reg(OFF_SINK0_CODE, 32'h40);
      wr_reg(OFF_PIN1_CONTROL, 32'h02);
      wr_reg(OFF_SINK1_CODE, 32'hff);
      repeat (3) @(posedge clk);
      #1;
      `CHK("sink enables", 2'b01, sink_en)
      `CHK("sink code", 8'h40, code0)
      wr_reg(OFF_PIN1_CONTROL, 32'h12);
      wr_reg(OFF_SINK1_CODE, 32'h01);
      repeat (3) @(posedge clk);
      #1;
      `CHK("sink enables", 2'b11, sink_en)
      `CHK("sink code 1", 8'h01, code1)
      wr_reg(OFF_RESET_STATUS, 32'h3f);
      wr_reg(OFF_RESET_CONTROL, 32'h3);
      wait_run(n);
      `CHK("release time", 1'b1, n >= 20 && n <= 80)
      rd_chk(OFF_RESET_CONTROL, 32'h2, "reset control");
      rd_chk(OFF_PIN0_CONTROL, 32'h0, "pin control");
      rd_chk(OFF_RESET_STATUS, 32'h4, "sw cause");
      `CHK("sinks off", 2'b00, sink_en)
      run_case(4'h2, 4'h8, 4'h0, 0, 60, 32'h0);
      run_case(4'h2, 4'h8, 4'h0, 0, 100, 32'h10);
      run_case(4'h2, 4'hc, 4'h0, 0, 55, 32'h10);
      run_case(4'h0, 4'h8, 4'h0, 0, 100, 32'h0);
      run_case(4'h2, 4'ha, 4'h0, 0, 100, 32'h0);
      run_case(4'h2, 4'h0, 4'h0, 0, 100, 32'h0);
      run_case(4'h0, 4'h0, 4'h1, 1, 20, 32'h0);
      run_case(4'h0, 4'h0, 4'h1, 1, 40, 32'h2);
      run_case(4'h0, 4'h0, 4'h3, 1, 4, 32'h0);
      run_case(4'h0, 4'h0, 4'h3, 1, 10, 32'h2);
      run_case(4'h0, 4'h0, 4'h0, 1, 40, 32'h0);
      run_case(4'h0, 4'h0, 4'h0, 2, 40, 32'h2);
      run_case(4'h0, 4'h0, 4'h8, 3, 5, 32'h20);
      run_case(4'h0, 4'h0, 4'h0, 3, 5, 32'h0);
      run_case(4'h0, 4'h0, 4'h0, 4, 3, 32'h8);
      // Power-ups from off: charger alone stays off, then battery or low-battery charger
      for (int w = 0; w < 2; w++) begin
         por <= 1'b0;
         rise <= 1'b0;
         chg <= 1'b1;
         boot_code <= 8'h00;
         arst_n <= 1'b0;
         repeat (2) @(posedge clk);
         arst_n <= 1'b1;
         rd_chk(OFF_STATE, 32'h0, "state off");
         if (w == 0) batt <= 1'b1;
         else below_fall <= 1'b1;
         @(posedge clk);
         batt <= 1'b0;
         below_fall <= 1'b0;
         rise <= 1'b1;
         wait_run(n);
         `CHK("zero timer release", 1'b1, n <= 15)
         rd_chk(OFF_RESET_STATUS, 32'h0, "wake cause");
      end
      give_verdict();
   end
endmodule
`default_nettype wire
